// File: shared/hub_text_cfg.svh
// Offsets, field positions, reset values and limits of the string/drive bank
`ifndef HUB_TEXT_CFG_SVH
`define HUB_TEXT_CFG_SVH
`define OFS_SERIAL_LEN 8'h15
`define OFS_MAKER_FIRST 8'h16
`define OFS_MAKER_LAST 8'h53
`define OFS_PRODUCT_FIRST 8'h54
`define OFS_PRODUCT_LAST 8'h91
`define OFS_SERIAL_FIRST 8'h92
`define OFS_SERIAL_LAST 8'hCF
`define OFS_CHARGE_EN 8'hD0
`define OFS_UP_BOOST 8'hF6
`define OFS_DN_BOOST 8'hF8
`define OFS_LAST_PROTECTED 8'hFE
`define AREA_BYTES 8'h3E
`define TEXT_MAX_CHARS 8'h1F
`define TEXT_MEM_DEPTH 186
`define TEXT_IDX_W 8
`define CHARGE_MASK 8'h06
`define UP_BOOST_MASK 8'h03
`define DN_BOOST_MASK 8'h0F
`define RESET_BYTE 8'h00
`endif

// File: shared/hub_text_pkg.sv
// Types shared by the string and drive configuration bank
package hub_text_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    BOOST_NORMAL,
    BOOST_PLUS4,
    BOOST_PLUS8,
    BOOST_PLUS12
  } boost_level_t;
  typedef enum logic [1:0] {
    TEXT_MAKER,
    TEXT_PRODUCT,
    TEXT_SERIAL,
    TEXT_NONE
  } text_area_t;
endpackage

// File: hw/text_byte_mem.sv
// Byte-wide string storage with registered read data and clear-to-zero reset
`timescale 1ns/1ns
`default_nettype none
`include "hub_text_cfg.svh"
module text_byte_mem
  import hub_text_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Write port
  input wire logic wr_en,
  input wire logic [7:0] wr_idx,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic [7:0] rd_idx,
  output logic [7:0] rd_data
);
  byte_t mem_reg [`TEXT_MEM_DEPTH];

  // Each byte is a flop so that every byte really resets to zero
  genvar i;
  generate
    for (i = 0; i < `TEXT_MEM_DEPTH; i++) begin : g_byte
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          mem_reg[i] <= `RESET_BYTE;
        end else if (wr_en && wr_idx == 8'(i)) begin
          mem_reg[i] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= `RESET_BYTE;
    end else if (rd_idx < 8'(`TEXT_MEM_DEPTH)) begin
      rd_data <= mem_reg[rd_idx];
    end else begin
      rd_data <= `RESET_BYTE;
    end
  end
endmodule
`default_nettype wire

// File: hw/hub_string_and_drive_config_bank.sv
// Serial length, descriptor strings, charging enables and drive boost bank
`timescale 1ns/1ns
`default_nettype none
`include "hub_text_cfg.svh"
// Overview of operation
// - Serial length register at 15h, reset zero
// - Maker string bytes at 16h-53h, reset zero
// - Product string bytes at 54h-91h, reset zero
// - Serial string bytes at 92h-CFh, reset zero
// - Each string at most 31 characters, 62 bytes
// - Charging enables at D0h, bits 2 and 1
// - Upstream boost in F6h bits 1:0
// - Port 2 boost in F8h bits 3:2
// - Port 1 boost in F8h bits 1:0
// - Attach blocks writes to 00h-FEh
module hub_string_and_drive_config_bank
  import hub_text_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Register port from the configuration slave
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  // Attach state, write protect source
  input wire logic ATTACHED,
  // String descriptor fetch
  input wire logic DESC_REQ,
  input wire logic [1:0] DESC_AREA,
  input wire logic [7:0] DESC_BYTE,
  output logic [7:0] DESC_DATA,
  output logic DESC_VALID,
  output logic DESC_END,
  // Settings to the port logic
  output logic PORT1_CHARGE_EN,
  output logic PORT2_CHARGE_EN,
  output logic [1:0] UPSTREAM_BOOST_LEVEL,
  output logic [1:0] PORT1_BOOST_LEVEL,
  output logic [1:0] PORT2_BOOST_LEVEL
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] serial_text_length_reg;
  logic [7:0] charging_port_enables_reg;
  logic [7:0] upstream_drive_boost_reg;
  logic [7:0] downstream_drive_boost_reg;
  logic wr_ok;
  logic in_text;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic [7:0] mem_rd;
  logic [7:0] desc_base;
  logic [7:0] desc_limit;
  logic desc_in_range;
  logic rd_text_reg;
  logic desc_pend_reg;
  logic [7:0] ctl_rd_reg;

  // Attach is write-once upstream, so a plain gate suffices here
  assign wr_ok = REG_WR && !ATTACHED && REG_ADDR <= `OFS_LAST_PROTECTED;
  assign in_text = REG_ADDR >= `OFS_MAKER_FIRST &&
                   REG_ADDR <= `OFS_SERIAL_LAST;
  assign wr_idx = REG_ADDR - `OFS_MAKER_FIRST;

  // Byte count allowed for the selected area, twice the character count
  always_comb begin
    desc_base = `OFS_MAKER_FIRST;
    desc_limit = `RESET_BYTE;
    unique case (text_area_t'(DESC_AREA))
      TEXT_MAKER: begin
        desc_base = `OFS_MAKER_FIRST;
        desc_limit = `AREA_BYTES;
      end
      TEXT_PRODUCT: begin
        desc_base = `OFS_PRODUCT_FIRST;
        desc_limit = `AREA_BYTES;
      end
      TEXT_SERIAL: begin
        desc_base = `OFS_SERIAL_FIRST;
        // Lengths above 31 are clamped rather than reading into the next area
        if (serial_text_length_reg > `TEXT_MAX_CHARS) begin
          desc_limit = `AREA_BYTES;
        end else begin
          desc_limit = {serial_text_length_reg[6:0], 1'b0};
        end
      end
      TEXT_NONE: begin
        desc_base = `OFS_MAKER_FIRST;
        desc_limit = `RESET_BYTE;
      end
    endcase
  end
  assign desc_in_range = DESC_BYTE < desc_limit;

  // Descriptor fetch takes priority over a register read on the read port
  assign rd_idx = DESC_REQ ? (desc_base - `OFS_MAKER_FIRST + DESC_BYTE)
                           : wr_idx;

  text_byte_mem u_mem (
    .clk(CLK),
    .reset_n(RESET_N),
    .wr_en(wr_ok && in_text),
    .wr_idx(wr_idx),
    .wr_data(REG_WDATA),
    .rd_idx(rd_idx),
    .rd_data(mem_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      serial_text_length_reg <= `RESET_BYTE;
    end else if (wr_ok && REG_ADDR == `OFS_SERIAL_LEN) begin
      serial_text_length_reg <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      charging_port_enables_reg <= `RESET_BYTE;
    end else if (wr_ok && REG_ADDR == `OFS_CHARGE_EN) begin
      charging_port_enables_reg <= REG_WDATA & `CHARGE_MASK;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      upstream_drive_boost_reg <= `RESET_BYTE;
    end else if (wr_ok && REG_ADDR == `OFS_UP_BOOST) begin
      upstream_drive_boost_reg <= REG_WDATA & `UP_BOOST_MASK;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      downstream_drive_boost_reg <= `RESET_BYTE;
    end else if (wr_ok && REG_ADDR == `OFS_DN_BOOST) begin
      downstream_drive_boost_reg <= REG_WDATA & `DN_BOOST_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads answer one cycle later; control registers are staged so
  // that they line up with the memory's registered output
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_text_reg <= 1'b0;
      ctl_rd_reg <= `RESET_BYTE;
      desc_pend_reg <= 1'b0;
    end else begin
      rd_text_reg <= in_text;
      desc_pend_reg <= DESC_REQ;
      unique case (REG_ADDR)
        `OFS_SERIAL_LEN: ctl_rd_reg <= serial_text_length_reg;
        `OFS_CHARGE_EN: ctl_rd_reg <= charging_port_enables_reg;
        `OFS_UP_BOOST: ctl_rd_reg <= upstream_drive_boost_reg;
        `OFS_DN_BOOST: ctl_rd_reg <= downstream_drive_boost_reg;
        default: ctl_rd_reg <= `RESET_BYTE;
      endcase
    end
  end

  // A read in the same cycle as a descriptor fetch is not served
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD && !DESC_REQ;
    end
  end
  assign REG_RDATA = rd_text_reg ? mem_rd : ctl_rd_reg;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DESC_VALID <= 1'b0;
      DESC_END <= 1'b0;
    end else begin
      DESC_VALID <= DESC_REQ && desc_in_range;
      DESC_END <= DESC_REQ && !desc_in_range;
    end
  end
  assign DESC_DATA = mem_rd;

  ////////////////////////////////////////////////////////////////////////////
  assign PORT1_CHARGE_EN = charging_port_enables_reg[1];
  assign PORT2_CHARGE_EN = charging_port_enables_reg[2];
  assign UPSTREAM_BOOST_LEVEL = upstream_drive_boost_reg[1:0];
  assign PORT2_BOOST_LEVEL = downstream_drive_boost_reg[3:2];
  assign PORT1_BOOST_LEVEL = downstream_drive_boost_reg[1:0];

  ////////////////////////////////////////////////////////////////////////////
  chk_attach_blocks: assert property (@(posedge CLK) disable iff (!RESET_N)
    ATTACHED && REG_WR |=> $stable(charging_port_enables_reg) &&
    $stable(serial_text_length_reg))
    else $error("write accepted while attached");
  chk_charge_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    REG_WR && !ATTACHED && REG_ADDR == 8'hD0 |=>
    charging_port_enables_reg == ($past(REG_WDATA) & 8'h06))
    else $error("charging enable write wrong");
  chk_up_boost_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    REG_WR && !ATTACHED && REG_ADDR == 8'hF6 |=>
    UPSTREAM_BOOST_LEVEL == $past(REG_WDATA[1:0]) &&
    upstream_drive_boost_reg[7:2] == 6'h00)
    else $error("upstream boost write wrong");
  chk_p2_boost_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    REG_WR && !ATTACHED && REG_ADDR == 8'hF8 |=>
    PORT2_BOOST_LEVEL == $past(REG_WDATA[3:2]))
    else $error("port 2 boost write wrong");
  chk_p1_boost_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    REG_WR && !ATTACHED && REG_ADDR == 8'hF8 |=>
    PORT1_BOOST_LEVEL == $past(REG_WDATA[1:0]) &&
    downstream_drive_boost_reg[7:4] == 4'h0)
    else $error("port 1 boost write wrong");
  chk_len_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    REG_WR && !ATTACHED && REG_ADDR == 8'h15 |=>
    serial_text_length_reg == $past(REG_WDATA))
    else $error("serial length write wrong");
  chk_text_readback: assert property (@(posedge CLK) disable iff (!RESET_N)
    REG_WR && !ATTACHED && in_text ##1 REG_RD && !REG_WR && !DESC_REQ &&
    REG_ADDR == $past(REG_ADDR) |=> REG_RVALID &&
    REG_RDATA == $past(REG_WDATA, 2))
    else $error("string byte read back wrong");
  chk_serial_limit: assert property (@(posedge CLK) disable iff (!RESET_N)
    DESC_REQ && DESC_AREA == 2'h2 && DESC_BYTE >= 8'h3E |=>
    DESC_END && !DESC_VALID)
    else $error("serial fetch past 62 bytes");
  chk_fetch_length: assert property (@(posedge CLK) disable iff (!RESET_N)
    DESC_REQ && DESC_AREA == 2'h2 && serial_text_length_reg <= 8'h1F |=>
    DESC_VALID == ($past(DESC_BYTE) < {$past(serial_text_length_reg[6:0]),
    1'b0}))
    else $error("serial fetch ignores length");
  cov_text_write: cover property (@(posedge CLK) disable iff (!RESET_N)
    wr_ok && in_text);
  cov_blocked_write: cover property (@(posedge CLK) disable iff (!RESET_N)
    REG_WR && ATTACHED);
  cov_fetch_end: cover property (@(posedge CLK) disable iff (!RESET_N)
    DESC_VALID ##1 DESC_END);
endmodule
`default_nettype wire

// File: verif/cfg_master_model.sv
// Configuration master model that loads the bank over its register port
`timescale 1ns/1ns
`default_nettype none
module cfg_master_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Released data must not look like a held value
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    // Read in the very next cycle, the tightest order the port allows
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_wdata <= ~d;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
    v = reg_rvalid;
  endtask
  // Index is five bits, so up to 32 characters can be addressed; an area holds 31
  task automatic put_char(input logic [7:0] base, input logic [4:0] n,
                          input logic [15:0] c);
    wr(base + {2'b00, n, 1'b0}, c[7:0]);
    wr(base + {2'b00, n, 1'b0} + 8'h01, c[15:8]);
  endtask
endmodule
`default_nettype wire

// File: verif/hub_string_and_drive_config_bank_tb.sv
// Self-checking bench for the string and drive configuration bank
`timescale 1ns/1ns
`default_nettype none
module hub_string_and_drive_config_bank_tb
  import hub_text_pkg::*;
;
  logic clk, reset_n, reg_wr, reg_rd, reg_rvalid, attached;
  logic desc_req, desc_valid, desc_end, p1_chg, p2_chg;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, desc_byte, desc_data;
  logic [1:0] desc_area, up_lvl, p1_lvl, p2_lvl;
  int fails, n_tests, cycles;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  hub_string_and_drive_config_bank u_dut (.CLK(clk), .RESET_N(reset_n),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
    .ATTACHED(attached), .DESC_REQ(desc_req), .DESC_AREA(desc_area),
    .DESC_BYTE(desc_byte), .DESC_DATA(desc_data), .DESC_VALID(desc_valid),
    .DESC_END(desc_end), .PORT1_CHARGE_EN(p1_chg), .PORT2_CHARGE_EN(p2_chg),
    .UPSTREAM_BOOST_LEVEL(up_lvl), .PORT1_BOOST_LEVEL(p1_lvl),
    .PORT2_BOOST_LEVEL(p2_lvl));
  cfg_master_model u_master (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [9:0] seen,
                       input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // A missing read strobe shows up as a mismatch in the top bit
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    u_master.rd(a, d, v);
    check($sformatf("reg %h", a), {v, 1'b0, d}, {2'b10, exp});
  endtask
  task automatic fetch_chk(input logic [1:0] ar, input logic [7:0] idx,
                           input logic [9:0] exp);
    @(posedge clk);
    desc_req <= 1'b1;
    desc_area <= ar;
    desc_byte <= idx;
    @(posedge clk);
    desc_req <= 1'b0;
    #1;
    check($sformatf("fetch %0d %h", ar, idx),
          {desc_valid, desc_end, desc_end ? 8'h00 : desc_data}, exp);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] a [12] = '{8'h15, 8'h16, 8'h53, 8'h54, 8'h91, 8'h92,
                           8'hCF, 8'hD0, 8'hF6, 8'hF8, 8'h10, 8'hE0};
    foreach (a[i]) rd_chk(a[i], 8'h00);
    check("outs", {2'b00, p1_chg, p2_chg, up_lvl, p1_lvl, p2_lvl},
          10'h000);
    $display("t_reset done");
  endtask
  task automatic t_strings();
    logic [7:0] b [3] = '{8'h16, 8'h54, 8'h92};
    logic [7:0] d;
    logic v;
    foreach (b[j]) begin
      u_master.put_char(b[j], 5'd0, {8'h00, 8'h41 + 8'(j)});
      u_master.put_char(b[j], 5'd30, {8'h5A, 8'h61 + 8'(j)});
      rd_chk(b[j], 8'h41 + 8'(j));
      rd_chk(b[j] + 8'd60, 8'h61 + 8'(j));
      rd_chk(b[j] + 8'd61, 8'h5A);
    end
    u_master.wr_rd(8'h90, 8'hC3, d, v);
    check("back to back", {v, 1'b0, d}, 10'h2C3);
    $display("t_strings done");
  endtask
  task automatic t_fields();
    logic [1:0] l;
    for (int i = 0; i < 4; i++) begin
      l = 2'(i);
      u_master.wr(8'hF6, {6'h3F, l});
      u_master.wr(8'hF8, {4'hF, l, ~l});
      u_master.wr(8'hD0, {5'h1F, l, 1'b1});
      rd_chk(8'hF6, {6'h00, l});
      rd_chk(8'hF8, {4'h0, l, ~l});
      rd_chk(8'hD0, {5'h00, l, 1'b0});
      check("levels", {4'h0, up_lvl, p2_lvl, p1_lvl}, {4'h0, l, l, ~l});
      check("charge", {8'h00, p2_chg, p1_chg}, {8'h00, l});
    end
    $display("t_fields done");
  endtask
  task automatic t_fetch();
    logic [7:0] d;
    logic v;
    u_master.wr(8'h15, 8'h02);
    rd_chk(8'h15, 8'h02);
    fetch_chk(2'd2, 8'h00, 10'h243);
    fetch_chk(2'd2, 8'h03, 10'h200);
    fetch_chk(2'd2, 8'h04, 10'h100);
    // Two fetches back to back: last byte inside the length, then the end
    @(posedge clk);
    desc_req <= 1'b1;
    desc_area <= 2'd2;
    desc_byte <= 8'h03;
    @(posedge clk);
    desc_byte <= 8'h04;
    #1;
    check("burst 3", {desc_valid, desc_end, desc_data}, 10'h200);
    @(posedge clk);
    desc_req <= 1'b0;
    #1;
    check("burst 4", {8'h00, desc_valid, desc_end}, 10'h001);
    u_master.wr(8'h15, 8'h28);
    fetch_chk(2'd2, 8'h3D, 10'h25A);
    fetch_chk(2'd2, 8'h3E, 10'h100);
    fetch_chk(2'd0, 8'h3D, 10'h25A);
    fetch_chk(2'd1, 8'h3E, 10'h100);
    fetch_chk(2'd3, 8'h00, 10'h100);
    u_master.wr(8'h15, 8'h00);
    fetch_chk(2'd2, 8'h00, 10'h100);
    // A register read that meets a fetch in one cycle gets no answer
    fork
      u_master.rd(8'h15, d, v);
      begin
        @(posedge clk);
        desc_req <= 1'b1;
        desc_byte <= 8'h00;
        @(posedge clk);
        desc_req <= 1'b0;
      end
    join
    check("collide", {7'h00, v, desc_valid, desc_end}, 10'h001);
    $display("t_fetch done");
  endtask
  task automatic t_attach();
    @(posedge clk);
    attached <= 1'b1;
    u_master.wr(8'h15, 8'h77);
    u_master.wr(8'hD0, 8'h00);
    u_master.wr(8'h16, 8'hFF);
    rd_chk(8'h15, 8'h00);
    rd_chk(8'hD0, 8'h06);
    rd_chk(8'h16, 8'h41);
    check("charge", {8'h00, p2_chg, p1_chg}, 10'h003);
    attached <= 1'b0;
    $display("t_attach done");
  endtask
  task automatic t_midreset();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    // Loaded strings and settings must all fall back to zero
    t_reset();
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Whole run is well under 2000 cycles; the ceiling leaves a wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    reset_n = 1'b0;
    attached = 1'b0;
    desc_req = 1'b0;
    desc_area = 2'h0;
    desc_byte = 8'h00;
    fails = 0;
    n_tests = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_strings();
    t_fields();
    t_fetch();
    t_attach();
    t_midreset();
    final_report();
  end
endmodule
`default_nettype wire
